// >>> peripheral_irq_enable_priority_test.sv
`timescale 1ns/1ps
module peripheral_irq_enable_priority_test;
  import pieprio_pkg::*;
  // ****************************************************************
  // clock, reset, stimulus and reference state
  // ****************************************************************
  logic         pclk        = 1'b0;
  logic         presetn     = 1'b0;
  logic         psel        = 1'b0;
  logic         penable     = 1'b0;
  logic         pwrite      = 1'b0;
  logic [7:0]   paddr       = 8'h00;
  logic [31:0]  pwdata      = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         irq_high;
  logic         irq_low;
  logic         irq;
  logic [31:0]  prdata_s;             // outputs of the smallest package option
  logic         pready_s;
  logic         pslverr_s;
  logic         irq_high_s;
  logic         irq_low_s;
  logic         irq_s;
  logic [32:0]  resp_small;           // bus answer of the small option
  pieprio_src_s src_flag;
  pieprio_src_s req_flags   = '0;     // flags asked of the peripherals
  logic [7:0]   gate_a;
  logic [7:0]   req_gate    = 8'h00;
  integer       seed        = 69;
  integer       miscompares = 0;
  integer       compares    = 0;
  logic [7:0]   regs [12];            // reference copy, index = address / 4
  logic [23:0]  act_prev    = '0;     // enabled flags at the previous update
  // writable bits: unimplemented and read-only places keep their value
  logic [7:0]   wmask [12]  = '{8'hfb, 8'hcf, 8'hff, 8'hfb, 8'hff, 8'hb3,
                                8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff};
  // bits that exist on the small option without microcontroller mode
  logic [7:0]   xmask [12]  = '{8'hff, 8'h0f, 8'h7f, 8'hff, 8'h0f, 8'hff,
                                8'h7f, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff};
  logic [23:0]  xsrc        = 24'h7f_ff_0f;  // existing sources, groups a b c

  always #10 pclk = ~pclk;

  pieprio_ctrl #(.PKG_OPTION(2'd2), .MCU_MODE(1'b1)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_flag(src_flag), .gate_a(gate_a), .irq_high(irq_high), .irq_low(irq_low), .irq(irq));

  pieprio_ctrl #(.PKG_OPTION(2'd0), .MCU_MODE(1'b0)) i_dut_small (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata_s), .pready(pready_s), .pslverr(pslverr_s),
    .src_flag(src_flag), .gate_a(gate_a), .irq_high(irq_high_s), .irq_low(irq_low_s), .irq(irq_s));

  pieprio_periph_model i_periph (
    .pclk(pclk), .presetn(presetn), .req_flags(req_flags), .req_gate(req_gate),
    .src_flag(src_flag), .gate_a(gate_a));

  // ****************************************************************
  // compare, bus and closing tasks
  // ****************************************************************
  task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: bus answer %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_irq(input logic [2:0] got, input logic [2:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: irq high/low/event %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; the request stands until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [32:0] resp);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    resp       = {pslverr, prdata};
    // a small option that does not answer in the same cycle shows an impossible value
    resp_small = pready_s ? {pslverr_s, prdata_s} : 33'h1_ffff_ffff;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_reg(input int idx);
    logic [32:0] r;
    apb(1'b0, 8'(idx * 4), 32'h0, r);
    cmp_rd(r, {9'h0, 16'h0, regs[idx]});
    cmp_rd(resp_small, {9'h0, 16'h0, regs[idx] & xmask[idx]});
  endtask

  // write and update the reference; status words clear where a one is written
  task automatic wr_reg(input int idx, input logic [7:0] d);
    logic [32:0] r;
    apb(1'b1, 8'(idx * 4), {24'h0, d}, r);
    cmp_rd(r, 33'h0);
    cmp_rd(resp_small, 33'h0);
    if (idx >= 6 && idx <= 8) regs[idx] = regs[idx] & ~d;
    else regs[idx] = (regs[idx] & ~wmask[idx]) | (d & wmask[idx]);
  endtask

  // let inputs reach the outputs, then compare the three request lines
  task automatic settle_check();
    logic [23:0] en;
    logic [23:0] lvl;
    logic [23:0] act;
    logic        hi;
    logic        lo;
    logic        hi_s;
    logic        lo_s;
    repeat (4) @(posedge pclk);
    en  = {req_gate, regs[0], regs[1]};
    lvl = {regs[2], regs[3], regs[4]};
    act = req_flags & en;
    {regs[6], regs[7], regs[8]} = {regs[6], regs[7], regs[8]} | (act & ~act_prev);
    act_prev = act;
    if (regs[5][7]) begin
      hi = |(act & lvl);
      lo = |(act & ~lvl);
    end else begin
      hi = |act;
      lo = 1'b0;
    end
    cmp_irq({irq_high, irq_low, irq}, {hi, lo,
            |({regs[6], regs[7], regs[8]} & {regs[9], regs[10], regs[11]})});
    // absent sources never request on the small option
    hi_s = regs[5][7] ? |(act & xsrc & lvl) : |(act & xsrc);
    lo_s = regs[5][7] & |(act & xsrc & ~lvl);
    cmp_irq({irq_high_s, irq_low_s, irq_s}, {hi_s, lo_s,
            |({regs[6], regs[7], regs[8]} & xsrc & {regs[9], regs[10], regs[11]})});
  endtask

  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    logic [32:0] r;
    int          idx;
    logic [7:0]  d;
    regs = '{8'h00, 8'h00, 8'hff, 8'hfb, 8'hff, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 12; i++) rd_reg(i);
    // unmapped place: write ignored, read zero, error flagged
    apb(1'b1, 8'h30, 32'hff, r);
    cmp_rd(r, 33'h1_0000_0000);
    cmp_rd(resp_small, 33'h1_0000_0000);
    apb(1'b0, 8'h30, 32'h0, r);
    cmp_rd(r, 33'h1_0000_0000);
    cmp_rd(resp_small, 33'h1_0000_0000);
    // every bit outside the status words set once, reserved places kept as software must keep them
    for (int i = 0; i < 12; i++) begin
      if (i < 6 || i > 8) begin
        wr_reg(i, (i == 0) ? 8'hef : 8'hff);
        rd_reg(i);
      end
    end
    // random traffic: registers, flags and group a enables together
    for (int k = 0; k < 80; k++) begin
      idx = ($random(seed) & 32'h7fffffff) % 12;
      d   = 8'($random(seed));
      if (idx == 0) d[4] = 1'b0;
      if (idx == 3) d[4] = 1'b1;
      wr_reg(idx, d);
      rd_reg(idx);
      settle_check();
      req_flags <= pieprio_src_s'(24'($random(seed)));
      req_gate  <= 8'($random(seed));
      settle_check();
    end
    // sticky status cleared by writing ones; the event line must fall
    req_flags <= '0;
    settle_check();
    for (int i = 6; i < 9; i++) begin
      wr_reg(i, 8'hff);
      rd_reg(i);
    end
    settle_check();
    report_and_stop();
  end

  // the run needs well under this; a hang ends as a failure
  initial begin
    #400000;
    miscompares++;
    report_and_stop();
  end
endmodule // peripheral_irq_enable_priority_test

// >>> pieprio_ctrl.sv
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - group b enable passes or masks sources
// - unimplemented bits read zero, ignore writes
// - group c enable gates its sources; link2 pair (bits 5:4) never passes
// - link2 enable bits read zero, read only
// - priority bits act only with priority on
// - level a bit one routes high
// - level b mirrors group b layout
// - level c mirrors group c layout
// - bit 7 selects two levels, resets off
// - reset cause flags; timeout, powerdown read only
// - some bits exist only on larger packages
module pieprio_ctrl
  import pieprio_pkg::*;
#(
  parameter logic [1:0] PKG_OPTION = 2'd2,  // package option
  parameter logic       MCU_MODE   = 1'b1   // microcontroller mode
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire pieprio_src_s src_flag,     // peripheral flag levels
  input  wire logic [7:0]   gate_a,       // enables of group a, held elsewhere
  output logic              irq_high,     // request on high priority path
  output logic              irq_low,      // request on low priority path
  output logic              irq           // masked sticky event interrupt
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // bits that exist on the chosen package option
  function automatic logic [7:0] exist_c();
    logic [7:0] m;
    m = 8'hff;
    if (PKG_OPTION != PKG_LARGEST) m = m & ~C_LARGE_BITS;
    if (PKG_OPTION != PKG_LARGEST && PKG_OPTION != PKG_MIDDLE) m = m & ~C_MIDDLE_BITS;
    return m;
  endfunction

  function automatic logic [7:0] exist_a();
    logic [7:0] m;
    m = 8'hff;
    if (PKG_OPTION != PKG_LARGEST || !MCU_MODE) m = m & ~A_PSP_BIT;
    return m;
  endfunction

  // merge write data into a register under a writable mask
  function automatic logic [7:0] wmerge(input logic [7:0] cur, input logic [7:0] wd,
                                        input logic [7:0] wm);
    return (cur & ~wm) | (wd & wm);
  endfunction

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic        wr_en;       // write takes effect this edge
  logic        addr_hit;    // address maps to a register
  logic [7:0]  wd;          // low byte of write data
  logic [7:0]  exist_c_m;   // existing group c bits
  logic [7:0]  exist_a_m;   // existing group a bits

  assign exist_c_m = exist_c();
  assign exist_a_m = exist_a();
  assign wd        = pwdata[7:0];
  assign wr_en     = psel & penable & pwrite & pready;

  always_comb begin
    case (paddr)
      ADDR_GATE_B, ADDR_GATE_C, ADDR_LEVEL_A, ADDR_LEVEL_B, ADDR_LEVEL_C,
      ADDR_RSTCTRL, ADDR_FLAGS_A, ADDR_FLAGS_B, ADDR_FLAGS_C,
      ADDR_MASK_A, ADDR_MASK_B, ADDR_MASK_C: addr_hit = 1'b1;
      default:                               addr_hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [7:0] gate_b_ff;     // periph_irq_gate_b
  logic [7:0] gate_c_ff;     // periph_irq_gate_c
  logic [7:0] level_a_ff;    // periph_irq_level_a
  logic [7:0] level_b_ff;    // periph_irq_level_b
  logic [7:0] level_c_ff;    // periph_irq_level_c
  logic [7:0] rstctrl_ff;    // reset_cause_and_level_ctrl
  logic [7:0] mask_ff [3];   // interrupt output masks, indexed by group
  logic [7:0] flags_ff [3];  // sticky event bits, indexed by group

  // enable registers; reserved bit 4 is stored as written, software keeps it zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_b_ff <= GATE_RST;
      gate_c_ff <= GATE_RST;
    end else if (wr_en) begin
      if (paddr == ADDR_GATE_B) gate_b_ff <= wmerge(gate_b_ff, wd, GATE_B_WMASK);
      if (paddr == ADDR_GATE_C) gate_c_ff <= wmerge(gate_c_ff, wd, GATE_C_WMASK & exist_c_m);
    end
  end

  // priority registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_a_ff <= LEVEL_A_RST;
      level_b_ff <= LEVEL_B_RST;
      level_c_ff <= LEVEL_C_RST;
    end else if (wr_en) begin
      if (paddr == ADDR_LEVEL_A) level_a_ff <= wmerge(level_a_ff, wd, exist_a_m);
      if (paddr == ADDR_LEVEL_B) level_b_ff <= wmerge(level_b_ff, wd, LEVEL_B_WMASK);
      if (paddr == ADDR_LEVEL_C) level_c_ff <= wmerge(level_c_ff, wd, exist_c_m);
    end
  end

  // reset control: priority enable plus cause flags; timeout and powerdown read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rstctrl_ff <= RSTCTRL_RST;
    end else if (wr_en && paddr == ADDR_RSTCTRL) begin
      rstctrl_ff <= wmerge(rstctrl_ff, wd, RSTCTRL_WMASK);
    end
  end

  // masks for the summary interrupt output; the output below reads the next
  // value so that it never lags a mask write by a cycle
  logic [7:0] nxt_mask [3];  // mask value after this edge

  assign nxt_mask[0] = (wr_en && paddr == ADDR_MASK_A) ? wd : mask_ff[0];
  assign nxt_mask[1] = (wr_en && paddr == ADDR_MASK_B) ? wd : mask_ff[1];
  assign nxt_mask[2] = (wr_en && paddr == ADDR_MASK_C) ? wd : mask_ff[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) mask_ff[i] <= MASK_RST;
    end else begin
      for (int i = 0; i < 3; i++) mask_ff[i] <= nxt_mask[i];
    end
  end

  // ****************************************************************
  // request routing
  // ****************************************************************
  logic [7:0] act_a;   // flagged and enabled, group a
  logic [7:0] act_b;   // flagged and enabled, group b
  logic [7:0] act_c;   // flagged and enabled, group c
  logic       any_hi;  // any active source routed high
  logic       any_lo;  // any active source routed low
  logic       prio_on; // two level mode

  assign prio_on = rstctrl_ff[PRIO_EN_BIT];
  assign act_a   = src_flag.grp_a & gate_a & exist_a_m;
  assign act_b   = src_flag.grp_b & gate_b_ff & GATE_B_WMASK;
  assign act_c   = src_flag.grp_c & gate_c_ff & exist_c_m;

  // priority bits only steer while two-level mode is on; otherwise everything
  // lands on the single compatibility path, which is the high one
  always_comb begin
    if (prio_on) begin
      any_hi = |(act_a & level_a_ff) | |(act_b & level_b_ff) | |(act_c & level_c_ff);
      any_lo = |(act_a & ~level_a_ff) | |(act_b & ~level_b_ff) | |(act_c & ~level_c_ff);
    end else begin
      any_hi = |act_a | |act_b | |act_c;
      any_lo = 1'b0;
    end
  end

  // registered requests toward the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_high <= 1'b0;
      irq_low  <= 1'b0;
    end else begin
      irq_high <= any_hi;
      irq_low  <= any_lo;
    end
  end

  // ****************************************************************
  // sticky event status, write one to clear; a new rise beats the clear
  // ****************************************************************
  logic [7:0] act_q [3];   // last cycle's active vector, for rise detect
  logic [7:0] rise  [3];   // new activations this cycle
  logic [7:0] clr   [3];   // write-one-to-clear strobes

  assign rise[0] = act_a & ~act_q[0];
  assign rise[1] = act_b & ~act_q[1];
  assign rise[2] = act_c & ~act_q[2];
  assign clr[0]  = (wr_en && paddr == ADDR_FLAGS_A) ? wd : 8'h00;
  assign clr[1]  = (wr_en && paddr == ADDR_FLAGS_B) ? wd : 8'h00;
  assign clr[2]  = (wr_en && paddr == ADDR_FLAGS_C) ? wd : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        flags_ff[i] <= 8'h00;
        act_q[i]    <= 8'h00;
      end
    end else begin
      act_q[0] <= act_a;
      act_q[1] <= act_b;
      act_q[2] <= act_c;
      for (int i = 0; i < 3; i++) flags_ff[i] <= (flags_ff[i] & ~clr[i]) | rise[i];
    end
  end

  // summary interrupt, level, from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((flags_ff[0] & ~clr[0] | rise[0]) & nxt_mask[0])
           | |((flags_ff[1] & ~clr[1] | rise[1]) & nxt_mask[1])
           | |((flags_ff[2] & ~clr[2] | rise[2]) & nxt_mask[2]);
    end
  end

  // ****************************************************************
  // apb answer: one wait state, read data registered
  // ****************************************************************
  logic [7:0] rd_mux;  // read value of the addressed register

  always_comb begin
    case (paddr)
      ADDR_GATE_B:  rd_mux = gate_b_ff & GATE_B_WMASK;
      ADDR_GATE_C:  rd_mux = gate_c_ff & exist_c_m;
      ADDR_LEVEL_A: rd_mux = level_a_ff & exist_a_m;
      ADDR_LEVEL_B: rd_mux = level_b_ff & LEVEL_B_WMASK;
      ADDR_LEVEL_C: rd_mux = level_c_ff & exist_c_m;
      ADDR_RSTCTRL: rd_mux = rstctrl_ff;
      ADDR_FLAGS_A: rd_mux = flags_ff[0];
      ADDR_FLAGS_B: rd_mux = flags_ff[1];
      ADDR_FLAGS_C: rd_mux = flags_ff[2];
      ADDR_MASK_A:  rd_mux = mask_ff[0];
      ADDR_MASK_B:  rd_mux = mask_ff[1];
      ADDR_MASK_C:  rd_mux = mask_ff[2];
      default:      rd_mux = 8'h00;
    endcase
  end

  // pready rises in the second access cycle, drops right after completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_hit;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_lowpath_needs_prio: assert property (@(posedge pclk) disable iff (!presetn)
    irq_low |-> $past(prio_on))
    else $error("low path raised with priority off");

  chk_gateb_bit2_zero: assert property (@(posedge pclk) disable iff (!presetn)
    gate_b_ff[2] == 1'b0 && level_b_ff[2] == 1'b0 && rstctrl_ff[6] == 1'b0)
    else $error("unimplemented bit became set");

  chk_link2_readonly: assert property (@(posedge pclk) disable iff (!presetn)
    gate_c_ff[5:4] == 2'b00)
    else $error("link2 enable bits became set");

  chk_roflags_stay: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(rstctrl_ff[3:2]))
    else $error("read only cause flag changed");

  chk_gateb_masks: assert property (@(posedge pclk) disable iff (!presetn)
    (gate_b_ff == 8'h00 && gate_c_ff == 8'h00 && (gate_a & exist_a_m) == 8'h00)
    |=> !irq_high && !irq_low)
    else $error("request with all sources disabled");

  chk_single_level: assert property (@(posedge pclk) disable iff (!presetn)
    (!prio_on && (act_b != 8'h00)) |=> irq_high && !irq_low)
    else $error("compat mode not single path");

  chk_high_route: assert property (@(posedge pclk) disable iff (!presetn)
    (prio_on && |(act_a & level_a_ff)) |=> irq_high)
    else $error("high level source not routed high");

  chk_levelc_low: assert property (@(posedge pclk) disable iff (!presetn)
    (prio_on && |(act_c & ~level_c_ff)) |=> irq_low)
    else $error("low level source not routed low");

  chk_levelb_high: assert property (@(posedge pclk) disable iff (!presetn)
    (prio_on && |(act_b & level_b_ff)) |=> irq_high)
    else $error("level b source not routed high");

  chk_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not after one wait");

  chk_missing_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (gate_c_ff & ~exist_c_m) == 8'h00)
    else $error("absent source enable became set");

  chk_prio_off_low: assert property (@(posedge pclk) disable iff (!presetn)
    !prio_on |=> !irq_low)
    else $error("low path raised in single level mode");

  chk_levela_low: assert property (@(posedge pclk) disable iff (!presetn)
    (prio_on && |(act_a & ~level_a_ff)) |=> irq_low)
    else $error("level a source not routed low");

  chk_levelb_low: assert property (@(posedge pclk) disable iff (!presetn)
    (prio_on && |(act_b & ~level_b_ff)) |=> irq_low)
    else $error("level b source not routed low");

  chk_levelc_high: assert property (@(posedge pclk) disable iff (!presetn)
    (prio_on && |(act_c & level_c_ff)) |=> irq_high)
    else $error("level c source not routed high");

  chk_quiet_no_req: assert property (@(posedge pclk) disable iff (!presetn)
    (act_a == 8'h00 && act_b == 8'h00 && act_c == 8'h00) |=> !irq_high && !irq_low)
    else $error("request raised with no active source");

  chk_gateb_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_GATE_B) |=> gate_b_ff == ($past(wd) & GATE_B_WMASK))
    else $error("group b enable write not stored");

  chk_levela_absent: assert property (@(posedge pclk) disable iff (!presetn)
    (level_a_ff & ~exist_a_m) == (LEVEL_A_RST & ~exist_a_m))
    else $error("absent level a bit changed");

  // a new activation in the clearing cycle must survive the clear
  chk_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (rise[1] != 8'h00) |=> (flags_ff[1] & $past(rise[1])) == $past(rise[1]))
    else $error("event bit lost on rise");

  chk_flag_w1c: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_FLAGS_A) |=> (flags_ff[0] & $past(wd) & ~$past(rise[0])) == 8'h00)
    else $error("event bit not cleared by a one");

  chk_irq_summary: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |((flags_ff[0] & mask_ff[0]) | (flags_ff[1] & mask_ff[1]) | (flags_ff[2] & mask_ff[2])))
    else $error("event line differs from masked status");

  chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && !addr_hit) |=> pslverr)
    else $error("unmapped access answered without error");

endmodule // pieprio_ctrl

// >>> pieprio_periph_model.sv
`timescale 1ns/1ps
module pieprio_periph_model
  import pieprio_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire pieprio_src_s req_flags,  // flag levels the bench asks for
  input  wire logic [7:0]   req_gate,   // group a enables the bench asks for
  output pieprio_src_s      src_flag,   // flag levels seen by the controller
  output logic [7:0]        gate_a      // group a enables seen by the controller
);
  // ****************************************************************
  // peripherals raise and drop their flags on the system clock
  // ****************************************************************
  // registered so that every change lands just after an edge, like real logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_flag <= '0;
      gate_a   <= 8'h00;
    end else begin
      src_flag <= req_flags;
      gate_a   <= req_gate;
    end
  end
endmodule // pieprio_periph_model

// >>> pieprio_pkg.sv
package pieprio_pkg;

  // ****************************************************************
  // register byte addresses on the apb slave
  // ****************************************************************
  localparam logic [7:0] ADDR_GATE_B   = 8'h00;  // periph_irq_gate_b
  localparam logic [7:0] ADDR_GATE_C   = 8'h04;  // periph_irq_gate_c
  localparam logic [7:0] ADDR_LEVEL_A  = 8'h08;  // periph_irq_level_a
  localparam logic [7:0] ADDR_LEVEL_B  = 8'h0c;  // periph_irq_level_b
  localparam logic [7:0] ADDR_LEVEL_C  = 8'h10;  // periph_irq_level_c
  localparam logic [7:0] ADDR_RSTCTRL  = 8'h14;  // reset_cause_and_level_ctrl
  localparam logic [7:0] ADDR_FLAGS_A  = 8'h18;  // sticky event status, group a
  localparam logic [7:0] ADDR_FLAGS_B  = 8'h1c;  // sticky event status, group b
  localparam logic [7:0] ADDR_FLAGS_C  = 8'h20;  // sticky event status, group c
  localparam logic [7:0] ADDR_MASK_A   = 8'h24;  // irq output mask, group a
  localparam logic [7:0] ADDR_MASK_B   = 8'h28;  // irq output mask, group b
  localparam logic [7:0] ADDR_MASK_C   = 8'h2c;  // irq output mask, group c

  // ****************************************************************
  // writable bits, implemented bits and reset values
  // ****************************************************************
  localparam logic [7:0] GATE_B_WMASK  = 8'hfb;  // bit 2 unimplemented
  localparam logic [7:0] GATE_C_WMASK  = 8'hcf;  // bits 5:4 read only
  localparam logic [7:0] LEVEL_B_WMASK = 8'hfb;  // bit 2 unimplemented
  localparam logic [7:0] RSTCTRL_WMASK = 8'hb3;  // bit 6 none, bits 3:2 read only
  localparam logic [7:0] GATE_RST      = 8'h00;
  localparam logic [7:0] LEVEL_A_RST   = 8'hff;
  localparam logic [7:0] LEVEL_B_RST   = 8'hfb;
  localparam logic [7:0] LEVEL_C_RST   = 8'hff;
  localparam logic [7:0] RSTCTRL_RST   = 8'h3c;  // cm, ri, to, pd set; pen clear
  localparam logic [7:0] MASK_RST      = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PRIO_EN_BIT     = 7;  // two_level_priority_on
  localparam int RESERVED_B_BIT  = 4;  // reserved position in group b

  // package option: 0 = small, 1 = middle, 2 = largest
  localparam logic [1:0] PKG_LARGEST = 2'd2;
  localparam logic [1:0] PKG_MIDDLE  = 2'd1;
  // bits that exist per option in group c / group a
  localparam logic [7:0] C_LARGE_BITS  = 8'hc0;  // serial_port2, bus_collision2
  localparam logic [7:0] C_MIDDLE_BITS = 8'h30;  // serial_link2 rx/tx
  localparam logic [7:0] A_PSP_BIT     = 8'h80;  // parallel slave port

  // ****************************************************************
  // carrier for the three source groups
  // ****************************************************************
  typedef struct packed {
    logic [7:0] grp_a;  // level-a sources (enable held elsewhere)
    logic [7:0] grp_b;
    logic [7:0] grp_c;
  } pieprio_src_s;

endpackage : pieprio_pkg
